// *** core/dss_input_logic.sv ***
// How it works
// - At polarity 4 the terminal stop input is normally closed and the network stop input normally open.
// - At polarity 4 the drive runs only with the terminal stop on and the network stop off.
// - At polarity 0 both stops must be off to run, at polarity 2 both must be on, else output is cut.
// - A stop request from the internal controller counts like the network stop: normally open at polarity 0 and 4, normally closed at 2.
// - The stop function has its own terminal and also goes to any terminal mapped with code 24.
// - The stop cuts the output in panel, external and network command modes alike.
// - With switch condition 0 the second or third set takes effect as soon as its select turns on.
// - With switch condition 10 the second or third set takes effect only at constant speed.
// - The second set is chosen while its select input is on and the third-set select is off, under the switch condition.
// - The third set is chosen while its select is on, under the switch condition, and that select comes only from terminals mapped with code 9.
// - The second-set select has its own terminal and also goes to any terminal mapped with code 3.
// - Functions that have no third set keep their first-set values while the third set is chosen.
// - A chosen set switches every function that has an alternate set at once.
// - A function mapped to several terminals sees the OR of those terminals.
// - A shutoff decision cuts the output at once, with no ramp, so the motor coasts.
`timescale 1ns/1ns
module dss_input_logic (
  input  wire logic                                 clock,
  input  wire logic                                 sys_rst,
  input  wire logic                                 output_stop_input,
  input  wire logic                                 second_set_select,
  input  wire logic [dss_pkg::TERM_COUNT-1:0]       term_pins,
  input  wire logic                                 comm_stop_input,
  input  wire logic                                 plc_stop_request,
  input  wire logic [dss_pkg::TERM_COUNT*dss_pkg::CODE_W-1:0] terminal_function_map,
  input  wire logic [2:0]                           stop_input_polarity_setting,
  input  wire logic [3:0]                           set_switch_condition,
  input  wire logic                                 at_constant_speed,
  output logic                                      output_enable,
  output logic                                      output_shutoff,
  output logic [2:0]                                active_set,
  output logic [1:0]                                pair_set,
  output logic                                      third_set_select
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // OR of every terminal whose function code equals the one asked for
  function automatic logic mapped_or(
    input logic [dss_pkg::TERM_COUNT*dss_pkg::CODE_W-1:0] fmap,
    input logic [dss_pkg::TERM_COUNT-1:0]                 pins,
    input logic [dss_pkg::CODE_W-1:0]                     code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < dss_pkg::TERM_COUNT; i++)
    begin
      if (fmap[i*dss_pkg::CODE_W +: dss_pkg::CODE_W] == code)
      begin
        hit = hit | pins[i];
      end
    end
    return hit;
  endfunction : mapped_or

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for everything that arrives from outside the clock

  localparam int unsigned SYNC_W = dss_pkg::TERM_COUNT + 3;

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] clean_in;

  assign raw_in = {comm_stop_input, second_set_select, output_stop_input, term_pins};

  dss_pin_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .pin_in    (raw_in),
    .pin_clean (clean_in)
  );

  logic [dss_pkg::TERM_COUNT-1:0] term_clean;
  logic                           stop_ded_clean;
  logic                           second_ded_clean;
  logic                           comm_clean;

  assign term_clean       = clean_in[dss_pkg::TERM_COUNT-1:0];
  assign stop_ded_clean   = clean_in[dss_pkg::TERM_COUNT];
  assign second_ded_clean = clean_in[dss_pkg::TERM_COUNT+1];
  assign comm_clean       = clean_in[dss_pkg::TERM_COUNT+2];

  ////////////////////////////////////////////////////////////////////////
  // Resolved input functions

  logic term_stop;
  logic comm_stop;
  logic second_req;
  logic third_req;

  assign term_stop = stop_ded_clean
                   | mapped_or(terminal_function_map, term_clean, dss_pkg::FN_OUT_STOP);

  assign comm_stop = comm_clean | plc_stop_request;

  assign second_req = second_ded_clean
                    | mapped_or(terminal_function_map, term_clean, dss_pkg::FN_SECOND_SET);

  assign third_req = mapped_or(terminal_function_map, term_clean, dss_pkg::FN_THIRD_SET);

  ////////////////////////////////////////////////////////////////////////
  // Shutoff decision; the command-source mode has no say in it

  logic next_output_enable;
  logic next_output_shutoff;

  always_comb
  begin
    case (stop_input_polarity_setting)
      dss_pkg::POL_BOTH_NO: next_output_enable = !term_stop && !comm_stop;
      dss_pkg::POL_BOTH_NC: next_output_enable = term_stop && comm_stop;
      dss_pkg::POL_TERM_NC: next_output_enable = term_stop && !comm_stop;
      // Unknown settings fail safe
      default:              next_output_enable = 1'b0;
    endcase
    next_output_shutoff = !next_output_enable;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      output_enable  <= dss_pkg::RST_ENABLE;
      output_shutoff <= dss_pkg::RST_SHUTOFF;
    end
    else
    begin
      output_enable  <= next_output_enable;
      output_shutoff <= next_output_shutoff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parameter-set selection

  dss_pkg::dss_set_t set_state;
  dss_pkg::dss_set_t next_set_state;
  logic              switch_ok;
  logic [1:0]        next_pair_set;
  logic              next_third_sel;

  always_comb
  begin
    case (set_switch_condition)
      dss_pkg::SW_IMMEDIATE: switch_ok = 1'b1;
      dss_pkg::SW_CONST_SPD: switch_ok = at_constant_speed;
      default:               switch_ok = 1'b1;
    endcase
    if (switch_ok && third_req)
    begin
      next_set_state = dss_pkg::DSS_SET_THIRD;
    end
    else if (switch_ok && second_req)
    begin
      next_set_state = dss_pkg::DSS_SET_SECOND;
    end
    else
    begin
      next_set_state = dss_pkg::DSS_SET_FIRST;
    end
    case (next_set_state)
      dss_pkg::DSS_SET_SECOND: next_pair_set = dss_pkg::PAIR_SECOND;
      default:                 next_pair_set = dss_pkg::PAIR_FIRST;
    endcase
    next_third_sel = third_req;
  end

  // The state register is the port itself, so no second copy can drift from it
  assign active_set = set_state;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      set_state        <= dss_pkg::DSS_SET_FIRST;
      pair_set         <= dss_pkg::PAIR_FIRST;
      third_set_select <= 1'b0;
    end
    else
    begin
      set_state        <= next_set_state;
      pair_set         <= next_pair_set;
      third_set_select <= next_third_sel;
    end
  end

endmodule : dss_input_logic

// *** core/dss_pin_sync.sv ***
`timescale 1ns/1ns
module dss_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_clean
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_pin_clean;

  ////////////////////////////////////////////////////////////////////////
  // A bit changes only once stages two and three agree; stage one stays private
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      next_pin_clean[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_clean[i];
    end
  end

  // Three-flop chain, all cleared to the inactive level
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1    <= '0;
      stage2    <= '0;
      stage3    <= '0;
      pin_clean <= '0;
    end
    else
    begin
      stage1    <= pin_in;
      stage2    <= stage1;
      stage3    <= stage2;
      pin_clean <= next_pin_clean;
    end
  end

endmodule : dss_pin_sync

// *** core/dss_pkg.sv ***
package dss_pkg;

  // Terminal count and width of one function code
  localparam int unsigned TERM_COUNT = 12;
  localparam int unsigned CODE_W     = 8;

  // Stop-input polarity settings
  localparam logic [2:0] POL_BOTH_NO  = 3'h0;
  localparam logic [2:0] POL_BOTH_NC  = 3'h2;
  localparam logic [2:0] POL_TERM_NC  = 3'h4;

  // Set-switch conditions
  localparam logic [3:0] SW_IMMEDIATE = 4'h0;
  localparam logic [3:0] SW_CONST_SPD = 4'hA;

  // Input-terminal function codes
  localparam logic [CODE_W-1:0] FN_SECOND_SET = 8'h03;
  localparam logic [CODE_W-1:0] FN_THIRD_SET  = 8'h09;
  localparam logic [CODE_W-1:0] FN_OUT_STOP   = 8'h18;

  // Reset values of the outputs
  localparam logic RST_ENABLE  = 1'b0;
  localparam logic RST_SHUTOFF = 1'b1;

  // Active parameter set, one-hot
  typedef enum logic [2:0] {
    DSS_SET_FIRST  = 3'h1,
    DSS_SET_SECOND = 3'h2,
    DSS_SET_THIRD  = 3'h4
  } dss_set_t;

  // Set for functions that have only a first and a second set
  localparam logic [1:0] PAIR_FIRST  = 2'h1;
  localparam logic [1:0] PAIR_SECOND = 2'h2;

endpackage : dss_pkg

// *** sim/dss_props.sv ***
`timescale 1ns/1ns
module dss_props (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       output_stop_input,
  input wire logic       second_set_select,
  input wire logic       plc_stop_request,
  input wire logic [2:0] stop_input_polarity_setting,
  input wire logic [3:0] set_switch_condition,
  input wire logic       at_constant_speed,
  input wire logic       output_enable,
  input wire logic       output_shutoff,
  input wire logic [2:0] active_set,
  input wire logic [1:0] pair_set,
  input wire logic       third_set_select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // Pin held long enough to cross the synchroniser
  sequence s_stop_held;
    $rose(output_stop_input) && stop_input_polarity_setting == 3'h0
      ##1 (output_stop_input && stop_input_polarity_setting == 3'h0) [*5];
  endsequence
  sequence s_second_held;
    $rose(second_set_select) && set_switch_condition == 4'h0
      ##1 (second_set_select && set_switch_condition == 4'h0 && !third_set_select) [*5];
  endsequence
  ////////////////////////////////////////////////////////////
  a_shutoff_inverse: assert property (output_shutoff == !output_enable)
    else $error("shutoff is not the inverse of enable");
  a_stop_pin_cuts: assert property (s_stop_held |-> output_shutoff)
    else $error("held stop pin did not cut output");
  a_plc_stop_cuts: assert property ((stop_input_polarity_setting inside {3'h0, 3'h4}) && plc_stop_request
    |=> !output_enable) else $error("controller stop did not cut output");
  a_bad_polarity: assert property (!(stop_input_polarity_setting inside {3'h0, 3'h2, 3'h4})
    |=> output_shutoff) else $error("invalid polarity left output on");
  a_const_speed_gate: assert property (set_switch_condition == 4'hA && !at_constant_speed
    |=> active_set == 3'h1) else $error("set switched while ramping");
  a_second_select: assert property (s_second_held |-> active_set == 3'h2)
    else $error("second set not taken");
  a_third_wins: assert property (third_set_select && $past(set_switch_condition) == 4'h0
    |-> active_set == 3'h4) else $error("third set not taken");
  a_pair_follow: assert property (pair_set == ((active_set == 3'h2) ? 2'h2 : 2'h1))
    else $error("pair set disagrees with active set");
  a_set_onehot: assert property ($onehot(active_set))
    else $error("active set not one-hot");
endmodule : dss_props

bind dss_input_logic dss_props chk (
  .clock, .sys_rst, .output_stop_input, .second_set_select, .plc_stop_request,
  .stop_input_polarity_setting, .set_switch_condition, .at_constant_speed,
  .output_enable, .output_shutoff, .active_set, .pair_set, .third_set_select
);

// *** sim/dss_switch_model.sv ***
`timescale 1ns/1ns
// Field switches and network master; levels move just after a rising edge
module dss_switch_model (
  input  wire logic                          clock,
  output logic                               output_stop_input,
  output logic                               second_set_select,
  output logic [dss_pkg::TERM_COUNT-1:0]     term_pins,
  output logic                               comm_stop_input
);
  // All contacts open at power-up
  initial {output_stop_input, second_set_select, term_pins, comm_stop_input} = '0;
  // Levels hold until the next call; contact bounce is not modelled
  task automatic drive(input logic s, input logic r, input logic [11:0] t, input logic c);
    @(posedge clock);
    #5;
    {output_stop_input, second_set_select, term_pins, comm_stop_input} = {s, r, t, c};
  endtask : drive
endmodule : dss_switch_model

// *** sim/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        stop_pin, second_pin, comm_stop, plc_stop = 1'b0, at_speed = 1'b0;
  logic [11:0] term_pins;
  // Slot 2 third set, slot 3 second set, slot 5 stop
  logic [95:0] fmap = 96'h000000000000180003090000;
  logic [2:0]  pol = 3'h0;
  logic [3:0]  cond = 4'h0;
  logic        enable, shutoff, third;
  logic [2:0]  act;
  logic [1:0]  pair;
  int          err_count = 0, compares = 0, cycles = 0;
  ////////////////////////////////////////////////////////////
  always #25 clock = ~clock;
  dss_switch_model sw (.clock(clock), .output_stop_input(stop_pin), .second_set_select(second_pin),
    .term_pins(term_pins), .comm_stop_input(comm_stop));
  dss_input_logic uut (.clock(clock), .sys_rst(sys_rst), .output_stop_input(stop_pin),
    .second_set_select(second_pin), .term_pins(term_pins), .comm_stop_input(comm_stop),
    .plc_stop_request(plc_stop), .terminal_function_map(fmap), .stop_input_polarity_setting(pol),
    .set_switch_condition(cond), .at_constant_speed(at_speed), .output_enable(enable),
    .output_shutoff(shutoff), .active_set(act), .pair_set(pair), .third_set_select(third));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  // Eight edges covers the synchroniser plus the output register
  task automatic settle();
    repeat (8) @(posedge clock);
    #5;
  endtask : settle
  // Stop pin on slot 5 except at polarity 0; controller stop stands in for network at 4
  task automatic stop_case(input logic [2:0] p, input logic t, input logic c);
    logic exp;
    exp = (p == 3'h0) ? (!t && !c) : (p == 3'h2) ? (t && c) : (p == 3'h4) ? (t && !c) : 1'b0;
    sw.drive(p == 3'h0 && t, 1'b0, {6'h00, p != 3'h0 && t, 5'h00}, p != 3'h4 && c);
    pol = p;
    plc_stop = p == 3'h4 && c;
    settle();
    check("output_enable", 3'(enable), 3'(exp));
    check("output_shutoff", 3'(shutoff), 3'(!exp));
  endtask : stop_case
  task automatic set_case(input logic [3:0] c, input logic a, s, m, x, input logic [2:0] exp);
    sw.drive(1'b0, s, {8'h00, m, x, 2'h0}, 1'b0);
    cond = c;
    at_speed = a;
    settle();
    check("active_set", act, exp);
    check("pair_set", 3'(pair), (exp == 3'h2) ? 3'h2 : 3'h1);
    check("third_set_select", 3'(third), 3'(x));
  endtask : set_case
  ////////////////////////////////////////////////////////////
  // Cut a hang short well past the expected run length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      err_count++;
      end_sim();
    end
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    #5;
    sys_rst = 1'b0;
    check("reset_enable", 3'(enable), 3'h0);
    check("reset_set", act, 3'h1);
    $display("test reset done");
    for (int p = 0; p <= 4; p += 2)
      for (int k = 0; k < 4; k++)
        stop_case(3'(p), k[1], k[0]);
    stop_case(3'h3, 1'b1, 1'b0);
    $display("test stop table done");
    set_case(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h2);
    set_case(4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2);
    set_case(4'h0, 1'b0, 1'b1, 1'b1, 1'b0, 3'h2);
    set_case(4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h4);
    set_case(4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h4);
    set_case(4'hA, 1'b0, 1'b1, 1'b0, 1'b1, 3'h1);
    set_case(4'hA, 1'b1, 1'b1, 1'b0, 1'b0, 3'h2);
    set_case(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1);
    $display("test set select done");
    end_sim();
  end
endmodule : tb
